//--- verilog/load_model_relax_control.v
// Load-model selection, energy scaling, current thresholds and relaxation control
`timescale 1ns/1ps
`include "lmrc_defs.vh"
module load_model_relax_control #(
	parameter integer TICK_CYCLES = `LMRC_TICK_CYCLES,
	parameter integer PROFILES = 2,
	parameter integer PROFILE_BITS = 1
)(
	input wire clk,
	input wire sys_rst,
	input wire loadMode,
	input wire [2:0] loadSelect,
	input wire [3:0] energyScale,
	input wire signed [15:0] meanCurrentReading,
	input wire [15:0] voltage,
	input wire signed [15:0] prevMeanCurrent,
	input wire signed [15:0] presentMeanCurrent,
	input wire signed [15:0] prevMeanPower,
	input wire signed [15:0] presentMeanPower,
	input wire [15:0] designCapacity,
	input wire [15:0] designEnergy,
	input wire signed [15:0] hostRateValue,
	input wire signed [15:0] userRateCurrent,
	input wire signed [15:0] userRatePower,
	input wire [15:0] remainingChargeReading,
	input wire [15:0] availableEnergyReading,
	input wire [15:0] reserveCharge,
	input wire [15:0] reserveEnergy,
	input wire [7:0] tempRise,
	input wire [15:0] dsgThreshold,
	input wire [15:0] chgThreshold,
	input wire [15:0] quitCurrent,
	input wire [15:0] dsgRelaxTime,
	input wire [15:0] chgRelaxTime,
	input wire [15:0] quitRelaxTime,
	input wire [15:0] voltageSlope,
	input wire [PROFILE_BITS-1:0] profileSelect,
	input wire qmaxSeedWrite,
	input wire [15:0] qmaxSeed,
	input wire qmaxLearnValid,
	input wire [15:0] qmaxLearned,
	output reg loadModelFlag,
	output reg loadIsPower,
	output reg signed [31:0] loadValue,
	output reg signed [31:0] filteredCurrent,
	output reg [3:0] activeScale,
	output reg scaleRejected,
	output reg [19:0] designEnergyMilli,
	output reg [19:0] reserveEnergyMilli,
	output reg [19:0] lastRunPowerMilli,
	output reg [11:0] tempRiseScaled,
	output reg chargeReserveActive,
	output reg energyReserveActive,
	output reg [15:0] chargeReserveNoLoad,
	output reg [19:0] energyReserveNoLoad,
	output reg dsgFlowing,
	output reg chgFlowing,
	output reg relaxed,
	output reg ocvReady,
	output reg qmaxUpdate,
	output reg [15:0] qmaxActive
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

	function [15:0] magnitude;
		input signed [15:0] value;
		begin
			magnitude = value[15] ? (~value + 16'h1) : value;
		end
	endfunction

	function [19:0] scaleUp;
		input [15:0] value;
		input [3:0] scale;
		begin
			if (scale == `LMRC_SCALE_DECI)
				scaleUp = {value, 3'h0} + {3'h0, value, 1'b0};
			else
				scaleUp = {4'h0, value};
		end
	endfunction

	function signed [31:0] widen;
		input signed [15:0] value;
		begin
			widen = {{16{value[15]}}, value};
		end
	endfunction

////////////////////////////////////////////////////////////////////////////////
// Tick and filter

	wire tick;
	wire signed [31:0] lowpassValue;

	second_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(tick)
	);

	current_lowpass #(
		.DIVISOR(`LMRC_FILTER_DIV)
	) u_lowpass (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(tick),
		.sample(meanCurrentReading),
		.filtered(lowpassValue)
	);

////////////////////////////////////////////////////////////////////////////////
// Energy scale

	wire scaleLegal;
	wire [3:0] next_scale;
	assign scaleLegal = (energyScale == `LMRC_SCALE_UNIT) || (energyScale == `LMRC_SCALE_DECI);
	assign next_scale = scaleLegal ? energyScale : activeScale;

	wire [19:0] designEnergyScaled;
	wire [19:0] reserveEnergyScaled;
	wire signed [31:0] userPowerScaled;
	wire signed [31:0] lastPowerScaled;
	assign designEnergyScaled = scaleUp(designEnergy, next_scale);
	assign reserveEnergyScaled = scaleUp(reserveEnergy, next_scale);
	// Signed powers keep their sign through the x10 scale
	assign userPowerScaled = (next_scale == `LMRC_SCALE_DECI) ?
		widen(userRatePower) * `LMRC_POWER_UNIT : widen(userRatePower);
	assign lastPowerScaled = (next_scale == `LMRC_SCALE_DECI) ?
		widen(prevMeanPower) * `LMRC_POWER_UNIT : widen(prevMeanPower);

////////////////////////////////////////////////////////////////////////////////
// Load source selection

	wire signed [32:0] avgProduct;
	wire signed [32:0] filtProduct;
	wire signed [32:0] voltSigned;
	assign voltSigned = {17'h0, voltage};
	assign avgProduct = ($signed({{17{meanCurrentReading[15]}}, meanCurrentReading}) * voltSigned) / `LMRC_MILLI_DIV;
	assign filtProduct = ($signed({lowpassValue[31], lowpassValue}) * voltSigned) / `LMRC_MILLI_DIV;

	reg signed [31:0] next_load;
	always @*
	begin
		next_load = 32'sh0;
		if (loadMode == `LMRC_MODE_CURRENT)
		begin
			case (loadSelect)
			`LMRC_SEL_PREV: next_load = widen(prevMeanCurrent);
			`LMRC_SEL_AVERAGE: next_load = widen(meanCurrentReading);
			`LMRC_SEL_FILTERED: next_load = lowpassValue;
			`LMRC_SEL_DESIGN: next_load = {16'h0, designCapacity} / `LMRC_DESIGN_DIV;
			`LMRC_SEL_HOST: next_load = widen(hostRateValue);
			`LMRC_SEL_USER: next_load = widen(userRateCurrent);
			default: next_load = widen(presentMeanCurrent);
			endcase
		end
		else
		begin
			case (loadSelect)
			`LMRC_SEL_PREV: next_load = lastPowerScaled;
			`LMRC_SEL_AVERAGE: next_load = avgProduct[31:0];
			`LMRC_SEL_FILTERED: next_load = filtProduct[31:0];
			`LMRC_SEL_DESIGN: next_load = {12'h0, designEnergyScaled} / `LMRC_DESIGN_DIV;
			`LMRC_SEL_HOST: next_load = widen(hostRateValue) * `LMRC_POWER_UNIT;
			`LMRC_SEL_USER: next_load = userPowerScaled * `LMRC_POWER_UNIT;
			default: next_load = widen(presentMeanPower);
			endcase
		end
	end

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			loadModelFlag <= `LMRC_MODE_CURRENT;
			loadIsPower <= 1'b0;
			loadValue <= 32'sh0;
			filteredCurrent <= 32'sh0;
			activeScale <= `LMRC_SCALE_RESET;
			scaleRejected <= 1'b0;
			designEnergyMilli <= 20'h0;
			reserveEnergyMilli <= 20'h0;
			lastRunPowerMilli <= 20'h0;
			tempRiseScaled <= 12'h0;
		end
		else
		begin
			loadModelFlag <= loadMode;
			loadIsPower <= loadMode == `LMRC_MODE_POWER;
			loadValue <= next_load;
			filteredCurrent <= lowpassValue;
			activeScale <= next_scale;
			scaleRejected <= ~scaleLegal;
			designEnergyMilli <= designEnergyScaled;
			reserveEnergyMilli <= reserveEnergyScaled;
			lastRunPowerMilli <= lastPowerScaled[19:0];
			if (next_scale == `LMRC_SCALE_DECI)
				tempRiseScaled <= {tempRise, 3'h0} + {3'h0, tempRise, 1'b0};
			else
				tempRiseScaled <= {4'h0, tempRise};
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Reserve capacity

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			chargeReserveActive <= 1'b0;
			energyReserveActive <= 1'b0;
			chargeReserveNoLoad <= 16'h0;
			energyReserveNoLoad <= 20'h0;
		end
		else
		begin
			// Reserve is held back uncompensated so it survives past the zero point
			chargeReserveActive <= remainingChargeReading == 16'h0;
			chargeReserveNoLoad <= reserveCharge;
			energyReserveActive <= availableEnergyReading == 16'h0;
			energyReserveNoLoad <= reserveEnergyScaled;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Current thresholds

	wire dsgNow;
	wire chgNow;
	wire quietNow;
	wire [15:0] currentMag;
	assign currentMag = magnitude(meanCurrentReading);
	assign dsgNow = meanCurrentReading[15] && (currentMag > dsgThreshold);
	assign chgNow = !meanCurrentReading[15] && (currentMag > chgThreshold);
	assign quietNow = currentMag < quitCurrent;

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dsgFlowing <= 1'b0;
			chgFlowing <= 1'b0;
		end
		else
		begin
			dsgFlowing <= dsgNow;
			chgFlowing <= chgNow;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Relaxation state machine

	reg state;
	reg lastDir;
	reg [15:0] quietSecs;
	reg [15:0] busySecs;
	reg [15:0] relaxSecs;
	wire enterRelax;
	wire leaveRelax;
	wire relaxDue;
	assign relaxDue = (lastDir == `LMRC_DIR_DSG) ? (quietSecs >= dsgRelaxTime) : (quietSecs >= chgRelaxTime);
	assign enterRelax = quietNow && relaxDue;
	assign leaveRelax = (dsgNow || chgNow) && (busySecs >= quitRelaxTime);

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= `LMRC_ST_ACTIVE;
			lastDir <= `LMRC_DIR_DSG;
			quietSecs <= 16'h0;
			busySecs <= 16'h0;
			relaxSecs <= 16'h0;
		end
		else
		begin
			if (dsgNow)
				lastDir <= `LMRC_DIR_DSG;
			else if (chgNow)
				lastDir <= `LMRC_DIR_CHG;
			case (state)
			`LMRC_ST_ACTIVE:
			begin
				busySecs <= 16'h0;
				relaxSecs <= 16'h0;
				if (!quietNow)
					quietSecs <= 16'h0;
				else if (tick && quietSecs != 16'hFFFF)
					quietSecs <= quietSecs + 16'h1;
				if (enterRelax)
					state <= `LMRC_ST_RELAX;
			end
			`LMRC_ST_RELAX:
			begin
				quietSecs <= 16'h0;
				if (tick && relaxSecs != 16'hFFFF)
					relaxSecs <= relaxSecs + 16'h1;
				if (!(dsgNow || chgNow))
					busySecs <= 16'h0;
				else if (tick && busySecs != 16'hFFFF)
					busySecs <= busySecs + 16'h1;
				if (leaveRelax)
					state <= `LMRC_ST_ACTIVE;
			end
			default:
				state <= `LMRC_ST_ACTIVE;
			endcase
		end
	end

	wire ocvDue;
	assign ocvDue = (state == `LMRC_ST_RELAX) && (relaxSecs >= `LMRC_OCV_DELAY_TICKS);

////////////////////////////////////////////////////////////////////////////////
// Maximum chemical capacity per profile

	reg [15:0] qmaxStore [0:PROFILES-1];
	wire learnNow;
	assign learnNow = ocvDue && (voltageSlope < `LMRC_SLOPE_LIMIT_UV) && qmaxLearnValid && !leaveRelax;

	genvar p;
	generate
		for (p = 0; p < PROFILES; p = p + 1)
		begin : g_profile
			localparam integer PROFILE_ID = p;
			always @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
					qmaxStore[p] <= 16'h0;
				else if (profileSelect == PROFILE_ID[PROFILE_BITS-1:0])
				begin
					if (qmaxSeedWrite)
						qmaxStore[p] <= qmaxSeed;
					else if (learnNow)
						qmaxStore[p] <= qmaxLearned;
				end
			end
		end
	endgenerate

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			relaxed <= 1'b0;
			ocvReady <= 1'b0;
			qmaxUpdate <= 1'b0;
			qmaxActive <= 16'h0;
		end
		else
		begin
			relaxed <= (state == `LMRC_ST_RELAX) ? !leaveRelax : enterRelax;
			ocvReady <= ocvDue && !leaveRelax;
			qmaxUpdate <= learnNow && !qmaxSeedWrite;
			qmaxActive <= qmaxStore[profileSelect];
		end
	end
endmodule // load_model_relax_control

//--- pkg/lmrc_defs.vh
// Constants for the load-model and relaxation control block
`ifndef LMRC_DEFS_VH
`define LMRC_DEFS_VH
`define LMRC_CLK_HZ 200000000
`define LMRC_TICK_S 1
`define LMRC_TICK_CYCLES (`LMRC_CLK_HZ * `LMRC_TICK_S)
`define LMRC_MODE_CURRENT 1'b0
`define LMRC_MODE_POWER 1'b1
`define LMRC_SEL_PREV 3'h0
`define LMRC_SEL_PRESENT 3'h1
`define LMRC_SEL_AVERAGE 3'h2
`define LMRC_SEL_FILTERED 3'h3
`define LMRC_SEL_DESIGN 3'h4
`define LMRC_SEL_HOST 3'h5
`define LMRC_SEL_USER 3'h6
`define LMRC_SEL_RESET 3'h1
`define LMRC_SCALE_UNIT 4'h1
`define LMRC_SCALE_DECI 4'hA
`define LMRC_SCALE_RESET 4'h1
`define LMRC_DESIGN_DIV 32'sh5
`define LMRC_POWER_UNIT 32'shA
`define LMRC_MILLI_DIV 33'sh3E8
`define LMRC_FILTER_TC_S 14
`define LMRC_FILTER_DIV (`LMRC_FILTER_TC_S / `LMRC_TICK_S)
`define LMRC_OCV_DELAY_S 300
`define LMRC_OCV_DELAY_TICKS (`LMRC_OCV_DELAY_S / `LMRC_TICK_S)
`define LMRC_SLOPE_LIMIT_UV 16'h0001
`define LMRC_DIR_DSG 1'b0
`define LMRC_DIR_CHG 1'b1
`define LMRC_ST_ACTIVE 1'b0
`define LMRC_ST_RELAX 1'b1
`endif

//--- verilog/second_tick.v
// One-second enable pulse divided down from the system clock
`timescale 1ns/1ps
`include "lmrc_defs.vh"
module second_tick #(
	parameter integer TICK_CYCLES = `LMRC_TICK_CYCLES
)(
	input wire clk,
	input wire sys_rst,
	output reg tick
);
	reg [31:0] count;
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count <= 32'h0;
			tick <= 1'b0;
		end
		else if (count == TICK_CYCLES[31:0] - 32'h1)
		begin
			count <= 32'h0;
			tick <= 1'b1;
		end
		else
		begin
			count <= count + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule // second_tick

//--- verilog/current_lowpass.v
// First-order low-pass of the mean current, stepped once per tick
`timescale 1ns/1ps
`include "lmrc_defs.vh"
module current_lowpass #(
	parameter integer DIVISOR = `LMRC_FILTER_DIV
)(
	input wire clk,
	input wire sys_rst,
	input wire tick,
	input wire signed [15:0] sample,
	output reg signed [31:0] filtered
);
	wire signed [31:0] error;
	wire signed [31:0] step;
	assign error = {{16{sample[15]}}, sample} - filtered;
	assign step = error / $signed(DIVISOR);
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			filtered <= 32'sh0;
		else if (tick)
			filtered <= filtered + step;
	end
endmodule // current_lowpass

//--- dv/load_model_relax_control_asserts.sv
// Port-level property checker for the load-model and relaxation control block
`timescale 1ns/1ps
module load_model_relax_control_asserts (
	input wire clk,
	input wire sys_rst,
	input wire loadMode,
	input wire [2:0] loadSelect,
	input wire [3:0] energyScale,
	input wire signed [15:0] meanCurrentReading,
	input wire [15:0] designCapacity,
	input wire [15:0] designEnergy,
	input wire [15:0] remainingChargeReading,
	input wire [15:0] dsgThreshold,
	input wire [15:0] chgThreshold,
	input wire [15:0] quitCurrent,
	input wire [15:0] voltageSlope,
	input wire qmaxSeedWrite,
	input wire [15:0] qmaxSeed,
	input wire qmaxLearnValid,
	input wire [15:0] qmaxLearned,
	input wire loadModelFlag,
	input wire signed [31:0] loadValue,
	input wire [3:0] activeScale,
	input wire scaleRejected,
	input wire [19:0] designEnergyMilli,
	input wire chargeReserveActive,
	input wire dsgFlowing,
	input wire chgFlowing,
	input wire relaxed,
	input wire ocvReady,
	input wire qmaxUpdate,
	input wire [15:0] qmaxActive
);
// Magnitude of the mean current, one bit wider so full-scale negative fits
wire [16:0] mag = meanCurrentReading[15] ? 17'h0 - {1'b1, meanCurrentReading} : {1'b0, meanCurrentReading};
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
////////////////////////////////////////////////////////////////////////////////
chk_flag_mirror: assert property (1'b1 |=> loadModelFlag == $past(loadMode))
	else $error("model flag differs from load mode");
chk_code_four: assert property (!loadMode && loadSelect == 3'h4 |=> loadValue == 32'($past(designCapacity) / 16'h5))
	else $error("design rate is not capacity over five");
chk_scale_hold: assert property (!(energyScale inside {4'h1, 4'hA}) |=> scaleRejected && $stable(activeScale))
	else $error("illegal scale was not refused");
chk_scale_ten: assert property (energyScale == 4'hA |=> activeScale == 4'hA && designEnergyMilli == $past(designEnergy) * 20'hA)
	else $error("scale ten not applied to design energy");
chk_dsg_flow: assert property (1'b1 |=> dsgFlowing == $past(meanCurrentReading[15] && mag > dsgThreshold))
	else $error("discharge flow flag wrong");
chk_chg_flow: assert property (1'b1 |=> chgFlowing == $past(!meanCurrentReading[15] && mag > chgThreshold))
	else $error("charge flow flag wrong");
chk_reserve_zero: assert property (1'b1 |=> chargeReserveActive == $past(remainingChargeReading == 16'h0))
	else $error("charge reserve flag wrong");
chk_relax_quiet: assert property ($rose(relaxed) |-> $past(mag < quitCurrent))
	else $error("relaxation entered while current not quiet");
chk_relax_exit: assert property ($fell(relaxed) |-> $past(dsgFlowing || chgFlowing))
	else $error("relaxation left without current flowing");
chk_ocv_relaxed: assert property ($rose(ocvReady) |-> relaxed)
	else $error("open circuit reading outside relaxation");
chk_qmax_gate: assert property (qmaxUpdate |-> $past(voltageSlope) == 16'h0 && $past(qmaxLearnValid))
	else $error("capacity update without flat voltage");
chk_qmax_store: assert property (qmaxUpdate |-> ##[0:2] qmaxActive == $past(qmaxLearned))
	else $error("learned capacity not stored");
chk_seed_store: assert property (qmaxSeedWrite |-> ##[1:2] qmaxActive == $past(qmaxSeed))
	else $error("seed capacity not stored");
cov_relax: cover property ($rose(relaxed));
cov_ocv: cover property ($rose(ocvReady));
cov_qmax: cover property (qmaxUpdate);
cov_reject: cover property (scaleRejected);
endmodule // load_model_relax_control_asserts
bind load_model_relax_control load_model_relax_control_asserts chk_u (.clk, .sys_rst, .loadMode, .loadSelect,
	.energyScale, .meanCurrentReading, .designCapacity, .designEnergy, .remainingChargeReading, .dsgThreshold,
	.chgThreshold, .quitCurrent, .voltageSlope, .qmaxSeedWrite, .qmaxSeed, .qmaxLearnValid, .qmaxLearned,
	.loadModelFlag, .loadValue, .activeScale, .scaleRejected, .designEnergyMilli, .chargeReserveActive,
	.dsgFlowing, .chgFlowing, .relaxed, .ocvReady, .qmaxUpdate, .qmaxActive);

//--- dv/load_model_relax_control_tb_top.sv
// Self-checking bench for the load-model and relaxation control block
`timescale 1ns/1ps
module load_model_relax_control_tb_top;
logic clk = 1'b0;
logic sysRst = 1'b1;
logic loadMode, qmaxSeedWrite, qmaxLearnValid, profileSelect;
logic [2:0] loadSelect;
logic [3:0] energyScale;
logic [7:0] tempRise;
logic signed [15:0] meanCurrentReading, prevMeanCurrent, presentMeanCurrent, prevMeanPower, presentMeanPower;
logic signed [15:0] hostRateValue, userRateCurrent, userRatePower;
logic [15:0] voltage, designCapacity, designEnergy, remainingChargeReading, availableEnergyReading, reserveCharge;
logic [15:0] reserveEnergy, dsgThreshold, chgThreshold, quitCurrent, dsgRelaxTime, chgRelaxTime, quitRelaxTime;
logic [15:0] voltageSlope, qmaxSeed, qmaxLearned;
wire loadModelFlag, loadIsPower, scaleRejected, chargeReserveActive, energyReserveActive;
wire dsgFlowing, chgFlowing, relaxed, ocvReady, qmaxUpdate;
wire signed [31:0] loadValue, filteredCurrent;
wire [3:0] activeScale;
wire [19:0] designEnergyMilli, reserveEnergyMilli, lastRunPowerMilli, energyReserveNoLoad;
wire [11:0] tempRiseScaled;
wire [15:0] chargeReserveNoLoad, qmaxActive;
int n_fail = 0;
int check_count = 0;
int cycles = 0;
load_model_relax_control #(.TICK_CYCLES(10)) dut_u (.clk, .sys_rst(sysRst), .loadMode, .loadSelect, .energyScale,
	.meanCurrentReading, .voltage, .prevMeanCurrent, .presentMeanCurrent, .prevMeanPower, .presentMeanPower,
	.designCapacity, .designEnergy, .hostRateValue, .userRateCurrent, .userRatePower, .remainingChargeReading,
	.availableEnergyReading, .reserveCharge, .reserveEnergy, .tempRise, .dsgThreshold, .chgThreshold, .quitCurrent,
	.dsgRelaxTime, .chgRelaxTime, .quitRelaxTime, .voltageSlope, .profileSelect, .qmaxSeedWrite, .qmaxSeed,
	.qmaxLearnValid, .qmaxLearned, .loadModelFlag, .loadIsPower, .loadValue, .filteredCurrent, .activeScale,
	.scaleRejected, .designEnergyMilli, .reserveEnergyMilli, .lastRunPowerMilli, .tempRiseScaled,
	.chargeReserveActive, .energyReserveActive, .chargeReserveNoLoad, .energyReserveNoLoad, .dsgFlowing,
	.chgFlowing, .relaxed, .ocvReady, .qmaxUpdate, .qmaxActive);
////////////////////////////////////////////////////////////////////////////////
initial forever #2.5 clk = ~clk;
always @(posedge clk)
begin
	cycles++;
	if (cycles == 20000)
	begin
		n_fail++;
		tally_and_finish();
	end
end
task automatic cyc(input int n);
	repeat (n) @(negedge clk);
endtask
task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
	check_count++;
	if (seen !== exp)
	begin
		n_fail++;
		$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
	end
endtask
task automatic tally_and_finish;
	if (n_fail == 0 && check_count > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_select;
	logic signed [31:0] exp [2][8] = '{'{-300, -400, -500, 0, 400, -250, 150, -400},
		'{-900, -1100, -1850, 0, 1480, -2500, 600, -1100}};
	// Filter codes go first, while the filter still holds zero
	for (int p = 0; p < 2; p++)
		for (int m = 0; m < 2; m++)
			for (int s = 0; s < 8; s++)
				if ((s == 3) == (p == 0))
				begin
					meanCurrentReading = p ? -16'sh1F4 : 16'sh0;
					loadMode = m[0];
					loadSelect = s[2:0];
					cyc(3);
					check("loadModelFlag", loadModelFlag, m);
					check("loadIsPower", loadIsPower, m);
					check("loadValue", loadValue, exp[m][s]);
				end
endtask
task automatic t_filter;
	// A steady input lets the truncating filter settle 13 short of it
	meanCurrentReading = -16'sh1F4;
	cyc(1500);
	check("filteredCurrent", filteredCurrent, -487);
	loadMode = 1'b0;
	loadSelect = 3'h3;
	cyc(2);
	check("loadValue", loadValue, -487);
	loadMode = 1'b1;
	cyc(2);
	check("loadValue", loadValue, -1801);
endtask
task automatic t_scale;
	loadMode = 1'b1;
	loadSelect = 3'h6;
	energyScale = 4'hA;
	cyc(3);
	check("activeScale", activeScale, 10);
	check("loadValue", loadValue, 6000);
	check("lastRunPowerMilli", lastRunPowerMilli, 20'hFDCD8);
	check("designEnergyMilli", designEnergyMilli, 74000);
	check("reserveEnergyMilli", reserveEnergyMilli, 5000);
	check("tempRiseScaled", tempRiseScaled, 120);
	energyScale = 4'h7;
	cyc(3);
	check("scaleRejected", scaleRejected, 1);
	check("activeScale", activeScale, 10);
	energyScale = 4'h1;
	cyc(3);
	check("designEnergyMilli", designEnergyMilli, 7400);
	check("tempRiseScaled", tempRiseScaled, 12);
	check("lastRunPowerMilli", lastRunPowerMilli, 20'hFFC7C);
endtask
task automatic t_reserve;
	for (int z = 1; z >= 0; z--)
	begin
		remainingChargeReading = z ? 16'h0 : 16'h10;
		availableEnergyReading = z ? 16'h0 : 16'h10;
		cyc(3);
		check("chargeReserveActive", chargeReserveActive, z);
		check("energyReserveActive", energyReserveActive, z);
		check("chargeReserveNoLoad", chargeReserveNoLoad, 300);
		check("energyReserveNoLoad", energyReserveNoLoad, 500);
	end
endtask
task automatic t_flow;
	logic signed [15:0] cur [4] = '{-16'sh64, -16'sh32, 16'sh32, 16'sh28};
	for (int i = 0; i < 4; i++)
	begin
		meanCurrentReading = cur[i];
		cyc(2);
		check("dsgFlowing", dsgFlowing, i == 0);
		check("chgFlowing", chgFlowing, i == 2);
	end
endtask
task automatic t_relax;
	int n;
	meanCurrentReading = -16'sh64;
	cyc(40);
	check("relaxed", relaxed, 0);
	meanCurrentReading = 16'sh0;
	cyc(20);
	// A single loud cycle must restart the quiet count
	meanCurrentReading = -16'sh1E;
	cyc(1);
	meanCurrentReading = 16'sh0;
	cyc(20);
	check("relaxed", relaxed, 0);
	for (n = 0; n < 30 && relaxed !== 1'b1; n++) cyc(1);
	check("relaxed", relaxed, 1);
	cyc(2900);
	check("ocvReady", ocvReady, 0);
	for (n = 0; n < 150 && ocvReady !== 1'b1; n++) cyc(1);
	check("ocvReady", ocvReady, 1);
	voltageSlope = 16'h1;
	qmaxLearned = 16'h0ABC;
	qmaxLearnValid = 1'b1;
	for (n = 0; n < 5 && qmaxUpdate !== 1'b1; n++) cyc(1);
	check("qmaxUpdate", qmaxUpdate, 0);
	voltageSlope = 16'h0;
	for (n = 0; n < 5 && qmaxUpdate !== 1'b1; n++) cyc(1);
	check("qmaxUpdate", qmaxUpdate, 1);
	qmaxLearnValid = 1'b0;
	cyc(3);
	check("qmaxActive", qmaxActive, 16'h0ABC);
	meanCurrentReading = -16'sh64;
	cyc(8);
	check("relaxed", relaxed, 1);
	for (n = 0; n < 40 && relaxed !== 1'b0; n++) cyc(1);
	check("relaxed", relaxed, 0);
endtask
task automatic t_seed;
	profileSelect = 1'b1;
	qmaxSeed = 16'h1234;
	qmaxSeedWrite = 1'b1;
	cyc(1);
	qmaxSeedWrite = 1'b0;
	cyc(3);
	check("qmaxActive", qmaxActive, 16'h1234);
	profileSelect = 1'b0;
	cyc(3);
	check("qmaxActive", qmaxActive, 16'h0ABC);
endtask
task automatic t_reset;
	energyScale = 4'hA;
	cyc(2);
	sysRst = 1'b1;
	cyc(2);
	check("activeScale", activeScale, 1);
	check("qmaxActive", qmaxActive, 0);
	sysRst = 1'b0;
	cyc(2);
	check("activeScale", activeScale, 10);
	check("qmaxActive", qmaxActive, 0);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
	loadMode = 1'b0;
	loadSelect = 3'h1;
	energyScale = 4'h1;
	meanCurrentReading = 16'sh0;
	voltage = 16'hE74;
	prevMeanCurrent = -16'sh12C;
	presentMeanCurrent = -16'sh190;
	prevMeanPower = -16'sh384;
	presentMeanPower = -16'sh44C;
	designCapacity = 16'h7D0;
	designEnergy = 16'h1CE8;
	hostRateValue = -16'shFA;
	userRateCurrent = 16'sh96;
	userRatePower = 16'sh3C;
	remainingChargeReading = 16'h10;
	availableEnergyReading = 16'h10;
	reserveCharge = 16'h12C;
	reserveEnergy = 16'h1F4;
	tempRise = 8'h0C;
	dsgThreshold = 16'h32;
	chgThreshold = 16'h28;
	quitCurrent = 16'h14;
	dsgRelaxTime = 16'h3;
	chgRelaxTime = 16'h3;
	quitRelaxTime = 16'h2;
	voltageSlope = 16'h0;
	profileSelect = 1'b0;
	qmaxSeedWrite = 1'b0;
	qmaxSeed = 16'h0;
	qmaxLearnValid = 1'b0;
	qmaxLearned = 16'h0;
	repeat (20) @(negedge clk);
	sysRst = 1'b0;
	cyc(2);
	check("activeScale", activeScale, 1);
	t_select();
	t_filter();
	t_scale();
	t_reserve();
	t_flow();
	t_relax();
	t_seed();
	t_reset();
	tally_and_finish();
end
endmodule // load_model_relax_control_tb_top
